// *** logic/flash_consts.svh ***
// constants for the fail-safe flash controller
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ_STATUS 4'h8
`define REG_IRQ_MASK 4'hc
`define REG_TIMEOUT 4'h0
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_FAULT_BIT 0
`define EVT_FLASH_START 0
`define EVT_FLASH_STOP 1
`define EVT_FAULT 2
`define EVT_WIDTH 3
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 40000000
`define HALF_PERIOD_MS 500
`define HB_TIMEOUT_MS 3000
`define POWER_DOWN_S 5
`endif

// *** logic/flash_pkg.sv ***
// types for the fail-safe flash controller
package flash_pkg;
  typedef enum logic [1:0] {
    st_inhibit = 2'b00,
    st_flash = 2'b01,
    st_fault = 2'b11
  } flash_state_type;
endpackage

// *** logic/edge_timeout.sv ***
// heartbeat activity watcher: restarts a timeout on every toggle edge
`timescale 1ns/10ps
`include "flash_consts.svh"
module edge_timeout #(
  parameter int CNT_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic toggle_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic active_o
);
  logic last;
  logic [CNT_W-1:0] count;
  wire edge_seen = toggle_i ^ last;
  wire expired = (count >= limit_i);
  // ----------------------------------------
  // edge detect and window counter
  // ----------------------------------------
  // the window counts from the last edge; an edge restarts it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last <= 1'b0;
      count <= '0;
      active_o <= 1'b1;
    end else begin
      last <= toggle_i;
      if (edge_seen) begin
        count <= '0;
      end else if (!expired) begin
        count <= count + 1'b1;
      end
      active_o <= edge_seen | ~expired;
    end
  end
endmodule

// *** logic/fail_safe_flash_controller.sv ***
// fail-safe flash controller top with avalon register slave
// Function
// - flash yellow after host activity stops
// - flash only when mains above threshold
// - flash only when lamp feed absent
// - no flash while heartbeat keeps toggling
// - flash only while enable input high
// - set fault latch blocks all flashing
// - fault sets latch, outputs off, red
// - only power-down reset clears fault latch
// - relay drive on exactly while flashing
// - two independently switched flash channels
// - default alternating 500ms on and off
// - strap selects both channels in phase
// - green indicator while operating correctly
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "flash_consts.svh"
module fail_safe_flash_controller #(
  parameter int HALF_CYCLES = `CLK_HZ / 1000 * `HALF_PERIOD_MS,
  parameter int TIMEOUT_DEFAULT = `CLK_HZ / 1000 * `HB_TIMEOUT_MS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic heartbeat_i,
  input wire logic mains_ok_i,
  input wire logic lamp_feed_low_i,
  input wire logic flash_enable_i,
  input wire logic fault_detect_i,
  input wire logic sync_flash_strap_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic flash_a_o,
  output logic flash_b_o,
  output logic relay_drive_o,
  output logic red_led_o,
  output logic green_led_o,
  output logic irq_o
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // refused at elaboration: both timers need at least two counts to toggle
  if (HALF_CYCLES < 2 || TIMEOUT_DEFAULT < 2) begin : g_bad_counts
    $error("flash controller counts too small");
  end
  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  // a strap is read once so a loose jumper cannot shift phase mid-flash
  logic strap_taken;
  logic sync_mode;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_taken <= 1'b0;
      sync_mode <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      sync_mode <= sync_flash_strap_i;
    end
  end
  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  logic [31:0] timeout_limit;
  logic soft_fault;
  logic [`EVT_WIDTH-1:0] irq_status;
  logic [`EVT_WIDTH-1:0] irq_mask;
  logic fault_latch;
  logic heartbeat_active;
  logic phase;
  flash_pkg::flash_state_type state;
  flash_pkg::flash_state_type next_state;
  // one wait cycle per access: waitrequest drops the cycle after a request
  logic ack;
  wire req = (avs_read_i | avs_write_i) & ~ack;
  wire wr_take = avs_write_i & ack;
  wire sel_ctrl = (avs_address_i == `REG_CONTROL);
  wire sel_stat = (avs_address_i == `REG_STATUS);
  wire sel_isr = (avs_address_i == `REG_IRQ_STATUS);
  wire sel_imr = (avs_address_i == `REG_IRQ_MASK);
  wire wr_lane0 = wr_take & avs_byteenable_i[0];
  wire [31:0] status_word = {26'h000_0000, sync_mode, heartbeat_active, phase, fault_latch, state};
  wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, soft_fault} :
                       sel_stat ? status_word :
                       sel_isr ? {29'h0000_0000, irq_status} :
                       sel_imr ? {29'h0000_0000, irq_mask} : 32'h0000_0000;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack <= req;
      avs_waitrequest_o <= ~req;
      if (req) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // a software fault request only sets the latch; nothing here can clear it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_fault <= 1'b0;
      irq_mask <= 3'h0;
      timeout_limit <= TIMEOUT_DEFAULT;
    end else begin
      if (wr_lane0 && sel_ctrl) begin
        soft_fault <= avs_writedata_i[`CTRL_FAULT_BIT];
      end
      if (wr_lane0 && sel_imr) begin
        irq_mask <= avs_writedata_i[`EVT_WIDTH-1:0];
      end
    end
  end
  // ----------------------------------------
  // heartbeat watcher
  // ----------------------------------------
  edge_timeout #(.CNT_W(32)) u_watch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .toggle_i(heartbeat_i),
    .limit_i(timeout_limit),
    .active_o(heartbeat_active)
  );
  // ----------------------------------------
  // qualifiers and state machine
  // ----------------------------------------
  wire fault_evt = fault_detect_i | soft_fault;
  wire qualified = ~heartbeat_active & mains_ok_i & lamp_feed_low_i & flash_enable_i;
  always_comb begin
    next_state = state;
    unique case (state)
      flash_pkg::st_inhibit: begin
        if (fault_evt) begin
          next_state = flash_pkg::st_fault;
        end else if (qualified) begin
          next_state = flash_pkg::st_flash;
        end
      end
      flash_pkg::st_flash: begin
        if (fault_evt) begin
          next_state = flash_pkg::st_fault;
        end else if (!qualified) begin
          next_state = flash_pkg::st_inhibit;
        end
      end
      flash_pkg::st_fault: next_state = flash_pkg::st_fault;
      default: next_state = flash_pkg::st_fault;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= flash_pkg::st_inhibit;
      fault_latch <= 1'b0;
    end else begin
      state <= next_state;
      fault_latch <= fault_latch | fault_evt;
    end
  end
  // ----------------------------------------
  // half period timer and phase
  // ----------------------------------------
  logic [31:0] half_count;
  wire flashing = (state == flash_pkg::st_flash);
  wire half_done = (half_count == 32'(HALF_CYCLES - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_count <= 32'h0000_0000;
      phase <= 1'b0;
    end else if (!flashing) begin
      half_count <= 32'h0000_0000;
      phase <= 1'b0;
    end else if (half_done) begin
      half_count <= 32'h0000_0000;
      phase <= ~phase;
    end else begin
      half_count <= half_count + 32'h0000_0001;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // fault forces every drive off even in the same cycle it is reported
  wire run = flashing & ~fault_latch & ~fault_evt;
  wire next_a = run & ~phase;
  wire next_b = run & (sync_mode ? ~phase : phase);
  wire [`EVT_WIDTH-1:0] evt;
  assign evt[`EVT_FLASH_START] = run & ~relay_drive_o;
  assign evt[`EVT_FLASH_STOP] = ~run & relay_drive_o;
  assign evt[`EVT_FAULT] = fault_evt & ~fault_latch;
  wire [`EVT_WIDTH-1:0] isr_clr = (wr_lane0 && sel_isr) ? avs_writedata_i[`EVT_WIDTH-1:0] : 3'h0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_a_o <= 1'b0;
      flash_b_o <= 1'b0;
      relay_drive_o <= 1'b0;
      red_led_o <= 1'b0;
      green_led_o <= 1'b0;
      irq_status <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      flash_a_o <= next_a;
      flash_b_o <= next_b;
      relay_drive_o <= run;
      red_led_o <= fault_latch | fault_evt;
      green_led_o <= ~fault_latch & ~fault_evt;
      irq_status <= (irq_status & ~isr_clr) | evt; // set wins over clear
      irq_o <= |(irq_status & irq_mask);
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_fault_blocks_relay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_latch |=> !relay_drive_o && !flash_a_o && !flash_b_o)
    else $error("outputs active with fault latch set");
  a_fault_red_led: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_evt |=> red_led_o [*3])
    else $error("red led not held after fault");
  a_latch_sticks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(fault_latch) |=> fault_latch [*8])
    else $error("fault latch cleared without reset");
  a_relay_needs_mains: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(relay_drive_o) |-> $past(mains_ok_i, 2) && $past(lamp_feed_low_i, 2) && $past(flash_enable_i, 2))
    else $error("relay rose without qualifiers");
  a_no_flash_active: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    heartbeat_active |=> !flashing)
    else $error("flashing while heartbeat active");
  a_lamp_feed_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !lamp_feed_low_i |=> ##1 !relay_drive_o)
    else $error("relay on with lamp feed present");
  a_enable_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !flash_enable_i |=> ##1 !relay_drive_o)
    else $error("relay on with flash disabled");
  a_start_flash: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == flash_pkg::st_inhibit && qualified && !fault_evt) |=> flashing)
    else $error("flash did not start");
  a_relay_tracks_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    relay_drive_o == $past(state == flash_pkg::st_flash && !fault_latch && !fault_detect_i && !soft_fault))
    else $error("relay does not follow flashing");
  a_channel_phase: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    relay_drive_o |-> (sync_mode ? (flash_a_o == flash_b_o) : (flash_a_o != flash_b_o)))
    else $error("channel phase wrong");
  a_green_led: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_latch |=> !green_led_o)
    else $error("green led lit under fault");
  c_flash_seen: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(relay_drive_o));
  c_phase_flip: cover property (@(posedge clk_i) disable iff (!rst_n_i) relay_drive_o && $fell(flash_a_o));
  c_fault_flash: cover property (@(posedge clk_i) disable iff (!rst_n_i) relay_drive_o ##1 fault_latch);
  c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule

// *** tb/heartbeat_host.sv ***
// host-side heartbeat model that toggles the flasher inhibit line
`timescale 1ns/10ps
module heartbeat_host (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic slow_i,
  output logic heartbeat_o
);
  // ----------------------------------------
  // toggle generator
  // ----------------------------------------
  logic [4:0] count;
  // both rates stay inside the 20-cycle window; a stalled host simply stops toggling
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 5'h00;
      heartbeat_o <= 1'b0;
    end else if (run_i) begin
      count <= (count >= (slow_i ? 5'h0f : 5'h05)) ? 5'h00 : count + 5'h01;
      if (count == 5'h00) begin
        heartbeat_o <= ~heartbeat_o;
      end
    end
  end
endmodule

// *** tb/fail_safe_flash_controller_tb_top.sv ***
// self-checking bench for the fail-safe flash controller
`timescale 1ns/10ps
`include "flash_consts.svh"
module fail_safe_flash_controller_tb_top;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  localparam int HALF = 8;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mains_ok_i = 1'b1, lamp_feed_low_i = 1'b1, flash_enable_i = 1'b1, fault_detect_i = 1'b0;
  logic sync_flash_strap_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, hb_run = 1'b1, hb_slow = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o, rd;
  logic heartbeat, avs_waitrequest_o, flash_a_o, flash_b_o, relay_drive_o, red_led_o, green_led_o, irq_o;
  int failures = 0;
  int samples_checked = 0;
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  heartbeat_host u_heartbeat_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(hb_run), .slow_i(hb_slow),
    .heartbeat_o(heartbeat));
  // short half period and window keep the run brief
  fail_safe_flash_controller #(.HALF_CYCLES(HALF), .TIMEOUT_DEFAULT(20)) u_fail_safe_flash_controller (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .heartbeat_i(heartbeat), .mains_ok_i(mains_ok_i),
    .lamp_feed_low_i(lamp_feed_low_i), .flash_enable_i(flash_enable_i), .fault_detect_i(fault_detect_i),
    .sync_flash_strap_i(sync_flash_strap_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .flash_a_o(flash_a_o),
    .flash_b_o(flash_b_o), .relay_drive_o(relay_drive_o), .red_led_o(red_led_o),
    .green_led_o(green_led_o), .irq_o(irq_o));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    check("bus answer", n < 50, 1'b1);
  endtask
  task automatic await_relay(input logic v);
    int n;
    n = 0;
    while (relay_drive_o !== v && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    check("relay drive", relay_drive_o, v);
  endtask
  // toggling holds off flashing; a stall starts it with the selected phase pattern
  task automatic t_flash(input logic sync);
    int n;
    hb_run <= 1'b1;
    repeat (60) @(posedge clk_i);
    check("relay while toggling", relay_drive_o, 1'b0);
    hb_run <= 1'b0;
    await_relay(1'b1);
    check("flash_b first half", flash_b_o, sync);
    n = 0;
    while (flash_a_o === 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    check("half period", n, HALF);
    check("flash_b second half", flash_b_o, !sync);
    bus(1'b0, `REG_STATUS, 32'h0000_0000, rd);
    check("status state", {rd[5], rd[1:0]}, {sync, 2'b01});
    hb_run <= 1'b1;
    await_relay(1'b0);
  endtask
  // each qualifier alone must stop flashing; interrupt masking rides along
  task automatic t_qual;
    int i;
    bus(1'b1, `REG_IRQ_MASK, 32'h0000_0001, rd);
    hb_run <= 1'b0;
    await_relay(1'b1);
    repeat (3) @(posedge clk_i);
    check("irq on start", irq_o, 1'b1);
    bus(1'b1, `REG_IRQ_STATUS, 32'h0000_0001, rd);
    bus(1'b1, `REG_IRQ_MASK, 32'h0000_0000, rd);
    bus(1'b0, `REG_IRQ_STATUS, 32'h0000_0000, rd);
    check("start event cleared", {irq_o, rd[0]}, 2'b00);
    for (i = 0; i < 3; i++) begin
      {mains_ok_i, lamp_feed_low_i, flash_enable_i} <= ~(3'b100 >> i);
      await_relay(1'b0);
      {mains_ok_i, lamp_feed_low_i, flash_enable_i} <= 3'b111;
      await_relay(1'b1);
    end
    bus(1'b0, `REG_IRQ_STATUS, 32'h0000_0000, rd);
    check("masked events", {irq_o, rd[1:0]}, 3'b011);
    hb_run <= 1'b1;
    await_relay(1'b0);
  endtask
  // a fault latches until power-down, then the strap selects in-phase flashing
  task automatic t_fault;
    hb_slow <= 1'b1;
    hb_run <= 1'b0;
    await_relay(1'b1);
    fault_detect_i <= 1'b1;
    @(posedge clk_i);
    fault_detect_i <= 1'b0;
    await_relay(1'b0);
    check("fault outputs", {flash_a_o, flash_b_o, red_led_o, green_led_o}, 4'b0010);
    repeat (40) @(posedge clk_i);
    bus(1'b0, `REG_STATUS, 32'h0000_0000, rd);
    check("fault held", {relay_drive_o, rd[2:0]}, 4'b0111);
    rst_n_i <= 1'b0;
    sync_flash_strap_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("red after power-down", {red_led_o, green_led_o}, 2'b01);
    // a software fault request latches as well; writing zero must not clear it
    bus(1'b1, `REG_CONTROL, 32'h0000_0001, rd);
    repeat (2) @(posedge clk_i);
    check("soft fault leds", {relay_drive_o, red_led_o, green_led_o}, 3'b010);
    bus(1'b1, `REG_CONTROL, 32'h0000_0000, rd);
    bus(1'b0, `REG_STATUS, 32'h0000_0000, rd);
    check("soft fault held", rd[2:0], 3'b111);
    bus(1'b0, `REG_IRQ_STATUS, 32'h0000_0000, rd);
    check("fault event", rd[2], 1'b1);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("clear after second power-down", {red_led_o, green_led_o}, 2'b01);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    check("reset outputs", {avs_waitrequest_o, relay_drive_o, red_led_o, irq_o}, 4'b1000);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("green after reset", green_led_o, 1'b1);
    bus(1'b0, `REG_IRQ_MASK, 32'h0000_0000, rd);
    check("mask reset", rd, 32'h0000_0000);
    bus(1'b0, 4'h1, 32'h0000_0000, rd);
    check("unmapped read", rd, 32'h0000_0000);
    t_flash(1'b0);
    t_qual();
    t_fault();
    t_flash(1'b1);
    report_and_stop();
  end
endmodule
